/* File: rtl/seq_pkg.sv */
package seq_pkg;

	// Program memory variants.
	localparam int PC_W_SMALL = 10;
	localparam int PC_W_LARGE = 11;
	localparam int PC_W_MAX = 11;
	localparam int STACK_SMALL = 4;
	localparam int STACK_LARGE = 8;
	localparam int WORD_W = 16;

	localparam logic [10:0] RESET_VECTOR = 11'h000;

	// Register offsets on the register port.
	localparam logic [7:0] PC_LOW_OFF = 8'h00;
	localparam logic [7:0] TAB_PTR_LO_OFF = 8'h01;
	localparam logic [7:0] TAB_PTR_HI_OFF = 8'h02;
	localparam logic [7:0] TAB_HIGH_OFF = 8'h03;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] SEQSTAT_OFF = 8'h05;

	// Field positions.
	localparam int ST_CARRY_BIT = 0;
	localparam int ST_ZERO_BIT = 1;
	localparam int SQ_FULL_BIT = 4;
	localparam int SQ_HELD_BIT = 5;
	localparam int SQ_VALID_BIT = 6;

	// Reset values and the table high mask.
	localparam logic [7:0] TAB_PTR_LO_RST = 8'h00;
	localparam logic [7:0] TAB_HIGH_RST = 8'h00;
	localparam logic [7:0] TAB_HIGH_MASK = 8'hff;

	typedef enum logic [3:0] {
		PH_T1 = 4'b0001,
		PH_T2 = 4'b0010,
		PH_T3 = 4'b0100,
		PH_T4 = 4'b1000
	} phase_t;

	typedef enum logic [3:0] {
		OP_NEXT = 4'h0,
		OP_ALU = 4'h1,
		OP_SKIP = 4'h2,
		OP_JUMP = 4'h3,
		OP_CALL = 4'h4,
		OP_SUB_RETURN = 4'h5,
		OP_INT_RETURN = 4'h6,
		OP_TAB_PAGE = 4'h7,
		OP_TAB_LAST = 4'h8,
		OP_TAB_FULL = 4'h9
	} op_kind_t;

	typedef enum logic [3:0] {
		ALU_ADD = 4'h0,
		ALU_ADC = 4'h1,
		ALU_SUB = 4'h2,
		ALU_SBC = 4'h3,
		ALU_DAA = 4'h4,
		ALU_AND = 4'h5,
		ALU_OR = 4'h6,
		ALU_XOR = 4'h7,
		ALU_CPL = 4'h8,
		ALU_RR = 4'h9,
		ALU_RRC = 4'ha,
		ALU_RL = 4'hb,
		ALU_RLC = 4'hc,
		ALU_INC = 4'hd,
		ALU_DEC = 4'he,
		ALU_PASS = 4'hf
	} alu_func_t;

	typedef struct packed {
		op_kind_t kind;
		alu_func_t func;
		logic [7:0] opa;
		logic [7:0] opb;
		logic skip_on_zero;
		logic [PC_W_MAX-1:0] target;
	} op_t;

endpackage

/* File: rtl/seq_alu.sv */
`timescale 1ns/100ps
`default_nettype none
module seq_alu (
	// Operation
	input wire seq_pkg::alu_func_t func,
	input wire logic [7:0] opa,
	input wire logic [7:0] opb,
	input wire logic carry_in,
	// Result
	output logic [7:0] result,
	output logic carry_out,
	output logic carry_upd,
	output logic zero
);
	import seq_pkg::*;

	function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b, input logic c);
		add9 = {1'b0, a} + {1'b0, b} + {8'h00, c};
	endfunction

	always_comb begin
		logic [8:0] sum;
		sum = 9'h000;
		result = opa;
		carry_out = carry_in;
		carry_upd = 1'b0;
		case (func)
			ALU_ADD, ALU_ADC: begin
				sum = add9(opa, opb, (func == ALU_ADC) ? carry_in : 1'b0);
				result = sum[7:0];
				carry_out = sum[8];
				carry_upd = 1'b1;
			end
			// Carry set means no borrow, as in two's complement subtraction.
			ALU_SUB, ALU_SBC: begin
				sum = add9(opa, ~opb, (func == ALU_SBC) ? carry_in : 1'b1);
				result = sum[7:0];
				carry_out = sum[8];
				carry_upd = 1'b1;
			end
			ALU_DAA: begin
				sum = add9(opa, (opa[3:0] > 4'h9) ? 8'h06 : 8'h00, 1'b0);
				if (sum[8] || carry_in || sum[7:0] > 8'h99) begin
					sum = add9(sum[7:0], 8'h60, 1'b0);
					sum[8] = 1'b1;
				end
				result = sum[7:0];
				carry_out = sum[8];
				carry_upd = 1'b1;
			end
			ALU_AND: result = opa & opb;
			ALU_OR: result = opa | opb;
			ALU_XOR: result = opa ^ opb;
			ALU_CPL: result = ~opa;
			ALU_RR: result = {opa[0], opa[7:1]};
			ALU_RL: result = {opa[6:0], opa[7]};
			ALU_RRC: begin
				result = {carry_in, opa[7:1]};
				carry_out = opa[0];
				carry_upd = 1'b1;
			end
			ALU_RLC: begin
				result = {opa[6:0], carry_in};
				carry_out = opa[7];
				carry_upd = 1'b1;
			end
			ALU_INC: begin
				sum = add9(opa, 8'h01, 1'b0);
				result = sum[7:0];
			end
			ALU_DEC: begin
				sum = add9(opa, 8'hff, 1'b0);
				result = sum[7:0];
			end
			default: result = opb;
		endcase
		zero = (result == 8'h00);
	end

endmodule
`default_nettype wire

/* File: rtl/program_sequencer_table_read.sv */
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Counter steps by one per executed instruction unless control is transferred.
// - Only the counter low byte is visible to software, read and write.
// - Jumps, calls, interrupt entry and reset load the target into the counter.
// - A taken skip discards the prefetched instruction and runs a dummy cycle.
// - Writing the low byte jumps inside the current 256-word page only.
// - A low byte write branch inserts one dummy cycle for the prefetch.
// - The return stack holds counter values; stack contents are hidden, the level reads back in the sequencer status register.
// - Calls and interrupt acknowledges push the counter onto the stack.
// - Both return kinds pop the stack back into the counter.
// - Reset leaves the stack empty.
// - With a full stack an interrupt waits until a return frees a level.
// - A call on a full stack still runs and drops the oldest entry.
// - Stack depth is 4 levels small, 8 levels large.
// - ALU operations deliver their result and update zero; carry only for add, subtract, decimal adjust and rotates through carry.
// - ALU offers arithmetic, decimal adjust, logic, rotates, inc, dec, skips.
// - Execution starts at address zero after reset.
// - Program memory is 1K or 2K sixteen-bit words addressed by the counter.
// - Low and high table pointers form a full program memory address.
// - Table read gives low byte to a data register, high byte to table high.
// - Current-page table read offsets the pointer from the current page start.
// - Table high register is read-only; each table read overwrites it.
// - Every table read takes two instruction cycles.
// - Four phases form one instruction cycle; counter steps in the first, fetch in the second.
// - Jumps and calls take two instruction cycles.
module program_sequencer_table_read #(
	parameter bit LARGE_MEM = 1'b1,
	parameter int PC_W = LARGE_MEM ? seq_pkg::PC_W_LARGE : seq_pkg::PC_W_SMALL,
	parameter int DEPTH = LARGE_MEM ? seq_pkg::STACK_LARGE : seq_pkg::STACK_SMALL
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Program memory
	output logic [PC_W-1:0] prog_addr,
	input wire logic [seq_pkg::WORD_W-1:0] prog_data,
	// Decoder
	output logic [seq_pkg::WORD_W-1:0] instr_word,
	output logic [PC_W-1:0] instr_addr,
	output logic exec_valid,
	output logic cycle_end,
	input wire seq_pkg::op_t op_in,
	// Results
	output logic [7:0] alu_result,
	output logic alu_valid,
	output logic [7:0] tbl_low_data,
	output logic tbl_low_valid,
	// Interrupts
	input wire logic irq_req,
	input wire logic [PC_W-1:0] irq_vector,
	output logic irq_ack,
	output logic irq_return
);
	import seq_pkg::*;

	localparam int LVL_W = $clog2(DEPTH + 1);
	localparam int HI_W = PC_W - 8;

	function automatic logic [PC_W-1:0] in_page(input logic [PC_W-1:0] base,
		input logic [7:0] low);
		in_page = {base[PC_W-1:8], low};
	endfunction

	phase_t phase_reg, phase_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic [PC_W-1:0] prog_addr_reg, prog_addr_next;
	logic [PC_W-1:0] fetch_addr_reg, fetch_addr_next;
	logic [WORD_W-1:0] fetch_word_reg, fetch_word_next;
	logic [WORD_W-1:0] instr_word_reg, instr_word_next;
	logic [PC_W-1:0] instr_addr_reg, instr_addr_next;
	logic valid_reg, valid_next;
	logic tab_pend_reg, tab_pend_next;
	logic [PC_W-1:0] tab_addr_reg, tab_addr_next;
	logic low_wr_pend_reg, low_wr_pend_next;
	logic [7:0] low_wr_val_reg, low_wr_val_next;
	logic [PC_W-1:0] stack_reg [DEPTH];
	logic [PC_W-1:0] stack_next [DEPTH];
	logic [LVL_W-1:0] level_reg, level_next;
	logic [7:0] tab_ptr_lo_reg, tab_ptr_lo_next;
	logic [HI_W-1:0] tab_ptr_hi_reg, tab_ptr_hi_next;
	logic [7:0] tab_high_reg, tab_high_next;
	logic carry_reg, carry_next;
	logic zero_reg, zero_next;
	logic [7:0] alu_result_reg, alu_result_next;
	logic alu_valid_reg, alu_valid_next;
	logic [7:0] tbl_low_reg, tbl_low_next;
	logic tbl_low_valid_reg, tbl_low_valid_next;
	logic irq_ack_reg, irq_ack_next;
	logic irq_return_reg, irq_return_next;
	logic irq_held_reg, irq_held_next;
	logic [7:0] rdata_reg, rdata_next;
	logic full;
	logic irq_take;
	logic push;
	logic pop;
	logic [PC_W-1:0] push_val;
	logic [7:0] alu_res;
	logic alu_carry;
	logic alu_carry_upd;
	logic alu_zero;

	seq_alu u_alu (
		.func(op_in.func),
		.opa(op_in.opa),
		.opb(op_in.opb),
		.carry_in(carry_reg),
		.result(alu_res),
		.carry_out(alu_carry),
		.carry_upd(alu_carry_upd),
		.zero(alu_zero)
	);

	assign full = (level_reg == LVL_W'(DEPTH));

	always_comb begin
		case (phase_reg)
			PH_T1: phase_next = PH_T2;
			PH_T2: phase_next = PH_T3;
			PH_T3: phase_next = PH_T4;
			PH_T4: phase_next = PH_T1;
			default: phase_next = PH_T1;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			phase_reg <= PH_T1;
		end else begin
			phase_reg <= phase_next;
		end
	end

	always_comb begin
		pc_next = pc_reg;
		prog_addr_next = prog_addr_reg;
		fetch_addr_next = fetch_addr_reg;
		fetch_word_next = fetch_word_reg;
		instr_word_next = instr_word_reg;
		instr_addr_next = instr_addr_reg;
		valid_next = valid_reg;
		tab_pend_next = tab_pend_reg;
		tab_addr_next = tab_addr_reg;
		low_wr_pend_next = low_wr_pend_reg;
		low_wr_val_next = low_wr_val_reg;
		stack_next = stack_reg;
		level_next = level_reg;
		tab_ptr_lo_next = tab_ptr_lo_reg;
		tab_ptr_hi_next = tab_ptr_hi_reg;
		tab_high_next = tab_high_reg;
		carry_next = carry_reg;
		zero_next = zero_reg;
		alu_result_next = alu_result_reg;
		alu_valid_next = 1'b0;
		tbl_low_next = tbl_low_reg;
		tbl_low_valid_next = 1'b0;
		irq_ack_next = 1'b0;
		irq_return_next = 1'b0;
		irq_held_next = irq_req && full;
		irq_take = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		push_val = fetch_addr_reg;
		rdata_next = 8'h00;

		// Software writes; the table high byte ignores them.
		if (reg_wr) begin
			case (reg_addr)
				PC_LOW_OFF: begin
					low_wr_pend_next = 1'b1;
					low_wr_val_next = reg_wdata;
				end
				TAB_PTR_LO_OFF: tab_ptr_lo_next = reg_wdata;
				TAB_PTR_HI_OFF: tab_ptr_hi_next = reg_wdata[HI_W-1:0];
				STATUS_OFF: begin
					carry_next = reg_wdata[ST_CARRY_BIT];
					zero_next = reg_wdata[ST_ZERO_BIT];
				end
				default: ;
			endcase
		end

		// No stack access here; the level reads back at SEQSTAT_OFF
		if (reg_rd) begin
			case (reg_addr)
				PC_LOW_OFF: rdata_next = instr_addr_reg[7:0];
				TAB_PTR_LO_OFF: rdata_next = tab_ptr_lo_reg;
				TAB_PTR_HI_OFF: rdata_next = 8'(tab_ptr_hi_reg);
				TAB_HIGH_OFF: rdata_next = tab_high_reg;
				STATUS_OFF: rdata_next = {6'h00, zero_reg, carry_reg};
				SEQSTAT_OFF: begin
					rdata_next = 8'(level_reg);
					rdata_next[SQ_FULL_BIT] = full;
					rdata_next[SQ_HELD_BIT] = irq_held_reg;
					rdata_next[SQ_VALID_BIT] = valid_reg;
				end
				default: rdata_next = 8'h00;
			endcase
		end

		case (phase_reg)
			PH_T1: pc_next = pc_reg + 1'b1;
			PH_T2: begin
				fetch_word_next = prog_data;
				fetch_addr_next = prog_addr_reg;
				if (tab_pend_reg) begin
					prog_addr_next = tab_addr_reg;
				end
			end
			PH_T4: begin
				if (tab_pend_reg) begin
					tab_high_next = prog_data[15:8] & TAB_HIGH_MASK;
					tbl_low_next = prog_data[7:0];
					tbl_low_valid_next = 1'b1;
					tab_pend_next = 1'b0;
				end
				instr_word_next = fetch_word_reg;
				instr_addr_next = fetch_addr_reg;
				valid_next = 1'b1;
				irq_take = valid_reg && irq_req && !full && !low_wr_pend_reg;
				if (irq_take) begin
					push = 1'b1;
					push_val = instr_addr_reg;
					pc_next = irq_vector;
					valid_next = 1'b0;
					irq_ack_next = 1'b1;
				end else if (valid_reg) begin
					case (op_in.kind)
						OP_ALU: begin
							alu_result_next = alu_res;
							alu_valid_next = 1'b1;
							zero_next = alu_zero;
							if (alu_carry_upd) begin
								carry_next = alu_carry;
							end
						end
						OP_SKIP: begin
							alu_result_next = alu_res;
							alu_valid_next = 1'b1;
							if (alu_zero == op_in.skip_on_zero) begin
								valid_next = 1'b0;
							end
						end
						OP_JUMP: begin
							pc_next = op_in.target[PC_W-1:0];
							valid_next = 1'b0;
						end
						OP_CALL: begin
							push = 1'b1;
							pc_next = op_in.target[PC_W-1:0];
							valid_next = 1'b0;
						end
						OP_SUB_RETURN, OP_INT_RETURN: begin
							pop = 1'b1;
							pc_next = stack_reg[0];
							valid_next = 1'b0;
							irq_return_next = (op_in.kind == OP_INT_RETURN);
						end
						// Table read borrows the next cycle
						OP_TAB_PAGE, OP_TAB_LAST, OP_TAB_FULL: begin
							tab_pend_next = 1'b1;
							pc_next = fetch_addr_reg;
							valid_next = 1'b0;
							case (op_in.kind)
								OP_TAB_PAGE: tab_addr_next = in_page(instr_addr_reg, tab_ptr_lo_reg);
								OP_TAB_LAST: tab_addr_next = {{HI_W{1'b1}}, tab_ptr_lo_reg};
								default: tab_addr_next = {tab_ptr_hi_reg, tab_ptr_lo_reg};
							endcase
						end
						default: ;
					endcase
				end
				// A pending low byte write overrides the instruction's own target.
				if (low_wr_pend_reg) begin
					pc_next = in_page(instr_addr_reg, low_wr_val_reg);
					valid_next = 1'b0;
					low_wr_pend_next = reg_wr && (reg_addr == PC_LOW_OFF);
				end
				prog_addr_next = pc_next;
			end
			default: ;
		endcase

		// Shifting keeps the newest entry at index 0, so an overflow falls off the end.
		if (push) begin
			stack_next[0] = push_val;
			for (int i = 1; i < DEPTH; i++) begin
				stack_next[i] = stack_reg[i-1];
			end
			if (!full) begin
				level_next = level_reg + 1'b1;
			end
		end else if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				stack_next[i] = stack_reg[i+1];
			end
			stack_next[DEPTH-1] = '0;
			if (level_reg != '0) begin
				level_next = level_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pc_reg <= RESET_VECTOR[PC_W-1:0];
			prog_addr_reg <= RESET_VECTOR[PC_W-1:0];
			fetch_addr_reg <= RESET_VECTOR[PC_W-1:0];
			fetch_word_reg <= '0;
			instr_word_reg <= '0;
			instr_addr_reg <= RESET_VECTOR[PC_W-1:0];
			valid_reg <= 1'b0;
			tab_pend_reg <= 1'b0;
			tab_addr_reg <= '0;
			low_wr_pend_reg <= 1'b0;
			low_wr_val_reg <= 8'h00;
			for (int i = 0; i < DEPTH; i++) begin
				stack_reg[i] <= '0;
			end
			level_reg <= '0;
			tab_ptr_lo_reg <= TAB_PTR_LO_RST;
			tab_ptr_hi_reg <= '0;
			tab_high_reg <= TAB_HIGH_RST;
			carry_reg <= 1'b0;
			zero_reg <= 1'b0;
			alu_result_reg <= 8'h00;
			alu_valid_reg <= 1'b0;
			tbl_low_reg <= 8'h00;
			tbl_low_valid_reg <= 1'b0;
			irq_ack_reg <= 1'b0;
			irq_return_reg <= 1'b0;
			irq_held_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			pc_reg <= pc_next;
			prog_addr_reg <= prog_addr_next;
			fetch_addr_reg <= fetch_addr_next;
			fetch_word_reg <= fetch_word_next;
			instr_word_reg <= instr_word_next;
			instr_addr_reg <= instr_addr_next;
			valid_reg <= valid_next;
			tab_pend_reg <= tab_pend_next;
			tab_addr_reg <= tab_addr_next;
			low_wr_pend_reg <= low_wr_pend_next;
			low_wr_val_reg <= low_wr_val_next;
			stack_reg <= stack_next;
			level_reg <= level_next;
			tab_ptr_lo_reg <= tab_ptr_lo_next;
			tab_ptr_hi_reg <= tab_ptr_hi_next;
			tab_high_reg <= tab_high_next;
			carry_reg <= carry_next;
			zero_reg <= zero_next;
			alu_result_reg <= alu_result_next;
			alu_valid_reg <= alu_valid_next;
			tbl_low_reg <= tbl_low_next;
			tbl_low_valid_reg <= tbl_low_valid_next;
			irq_ack_reg <= irq_ack_next;
			irq_return_reg <= irq_return_next;
			irq_held_reg <= irq_held_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign prog_addr = prog_addr_reg;
	assign instr_word = instr_word_reg;
	assign instr_addr = instr_addr_reg;
	assign exec_valid = valid_reg;
	assign cycle_end = (phase_reg == PH_T4);
	assign alu_result = alu_result_reg;
	assign alu_valid = alu_valid_reg;
	assign tbl_low_data = tbl_low_reg;
	assign tbl_low_valid = tbl_low_valid_reg;
	assign irq_ack = irq_ack_reg;
	assign irq_return = irq_return_reg;

endmodule
`default_nettype wire

/* File: verif/prog_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Program memory
	input wire logic [9:0] prog_addr,
	output logic [15:0] prog_data,
	// Interrupt source
	input wire logic irq_raise,
	input wire logic irq_ack,
	output logic irq_req
);
	assign prog_data = {prog_addr[7:0] ^ 8'ha5, prog_addr[9:2]};
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq_req <= 1'b0;
		end else if (irq_ack) begin
			irq_req <= 1'b0;
		end else if (irq_raise) begin
			irq_req <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: verif/seq_checker_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module seq_checker
	import seq_pkg::*;
#(
	parameter int PC_W = 11,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [PC_W-1:0] instr_addr,
	input wire logic exec_valid,
	input wire logic cycle_end,
	input wire seq_pkg::op_t op_in,
	input wire logic alu_valid,
	input wire logic tbl_low_valid,
	input wire logic irq_req,
	input wire logic irq_ack,
	input wire logic irq_return
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic take, alu_take, tab_take, jmp_take, call_take, ipop_take;
	assign take = cycle_end && exec_valid;
	assign alu_take = take && op_in.kind inside {OP_ALU, OP_SKIP};
	assign tab_take = take && !irq_req && op_in.kind inside {OP_TAB_PAGE, OP_TAB_LAST, OP_TAB_FULL};
	assign jmp_take = take && !irq_req && op_in.kind == OP_JUMP;
	assign call_take = take && !irq_req && op_in.kind == OP_CALL;
	assign ipop_take = take && op_in.kind == OP_INT_RETURN;
	sequence bubble;
		(!exec_valid && !tbl_low_valid) [*4];
	endsequence
	sequence refetch;
		exec_valid && tbl_low_valid;
	endsequence
	phase_order_a: assert property (cycle_end |=> !cycle_end [*3] ##1 cycle_end)
		else $error("phase order broken");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside answer cycle");
	alu_cause_a: assert property (alu_valid |-> $past(alu_take) ##1 !alu_valid)
		else $error("alu result without alu op");
	jump_bubble_a: assert property (jmp_take |=> bubble ##1 exec_valid)
		else $error("jump without one dummy cycle");
	call_bubble_a: assert property (call_take |=> bubble ##1 exec_valid)
		else $error("call without one dummy cycle");
	table_two_a: assert property (tab_take |=> bubble ##1 refetch)
		else $error("table read not two cycles");
	ack_cause_a: assert property (irq_ack |-> $past(irq_req) && $past(cycle_end) ##1 !irq_ack)
		else $error("acknowledge without request");
	ipop_cause_a: assert property (irq_return |-> $past(ipop_take))
		else $error("interrupt return pulse without op");
	addr_hold_a: assert property (!cycle_end |=> $stable(instr_addr) && $stable(exec_valid))
		else $error("instruction changed mid cycle");
endmodule
bind program_sequencer_table_read seq_checker #(
	.PC_W(PC_W),
	.DEPTH(DEPTH)
) chk (
	.ref_clk(ref_clk), .rstn(rstn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.instr_addr(instr_addr), .exec_valid(exec_valid), .cycle_end(cycle_end), .op_in(op_in),
	.alu_valid(alu_valid), .tbl_low_valid(tbl_low_valid), .irq_req(irq_req),
	.irq_ack(irq_ack), .irq_return(irq_return)
);
`default_nettype wire

/* File: verif/program_sequencer_table_read_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module program_sequencer_table_read_tb_top;
	import seq_pkg::*;
	logic ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq_raise = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, alu_result, tbl_low_data, r, h;
	logic [9:0] prog_addr, instr_addr, a, b, c, irq_vector = 10'h300;
	logic [9:0] ra [5];
	logic [15:0] prog_data, instr_word, w;
	logic exec_valid, cycle_end, alu_valid, tbl_low_valid, irq_req, irq_ack, irq_return;
	op_t op_in = '0, o, back_op, iback_op;
	int fails = 0, checks = 0, acks = 0, rets = 0, d, seed;
	program_sequencer_table_read #(.LARGE_MEM(1'b0)) dut (
		.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_addr(prog_addr),
		.prog_data(prog_data), .instr_word(instr_word), .instr_addr(instr_addr),
		.exec_valid(exec_valid), .cycle_end(cycle_end), .op_in(op_in), .alu_result(alu_result),
		.alu_valid(alu_valid), .tbl_low_data(tbl_low_data), .tbl_low_valid(tbl_low_valid),
		.irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_return(irq_return)
	);
	prog_mem_model mem (
		.ref_clk(ref_clk), .rstn(rstn), .prog_addr(prog_addr), .prog_data(prog_data),
		.irq_raise(irq_raise), .irq_ack(irq_ack), .irq_req(irq_req)
	);
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (irq_ack === 1'b1) acks++;
		if (irq_return === 1'b1) rets++;
	end
	function automatic logic [15:0] mw(input logic [9:0] x);
		return {x[7:0] ^ 8'ha5, x[9:2]};
	endfunction
	function automatic op_t mk(input logic [3:0] k, f, input logic [7:0] x, y, input logic [9:0] t);
		return '{op_kind_t'(k), alu_func_t'(f), x, y, 1'b1, {1'b0, t}};
	endfunction
	function automatic bit alu_exp(input alu_func_t f, input logic [7:0] x, y, output logic [7:0] e);
		e = 8'h00;
		alu_exp = 1'b1;
		case (f)
			ALU_ADD: e = x + y;
			ALU_SUB: e = x - y;
			ALU_AND: e = x & y;
			ALU_OR: e = x | y;
			ALU_XOR: e = x ^ y;
			ALU_CPL: e = ~x;
			ALU_RR: e = {x[0], x[7:1]};
			ALU_RL: e = {x[6:0], x[7]};
			ALU_INC: e = x + 8'h01;
			ALU_DEC: e = x - 8'h01;
			default: alu_exp = 1'b0;
		endcase
	endfunction
	task automatic check(input bit ok, input string m);
		checks++;
		if (!ok) begin
			fails++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] ad, v);
		@(posedge ref_clk);
		reg_addr <= ad;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// Offers x for the next executed instruction; n counts dummy cycles seen first.
	task automatic ex(input op_t x, output logic [9:0] ad, output int n);
		n = 0;
		@(posedge ref_clk);
		op_in <= x;
		repeat (60) begin
			@(negedge ref_clk);
			if (cycle_end === 1'b1 && exec_valid === 1'b1) break;
			if (cycle_end === 1'b1) n++;
		end
		ad = instr_addr;
		@(posedge ref_clk);
		op_in <= '0;
		#1;
	endtask
	task automatic test_done();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// The whole sequence needs a few hundred cycles, so 25000 leaves a wide margin.
	initial begin
		#200000;
		fails++;
		test_done();
	end
	initial begin
		seed = $urandom(32'h2558);
		back_op = mk(4'h5, 4'h0, 8'h00, 8'h00, 10'h000);
		iback_op = mk(4'h6, 4'h0, 8'h00, 8'h00, 10'h000);
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		irq_vector <= 10'h300 | (10'($urandom) & 10'h0fe);
		ex('0, a, d);
		check(a === 10'h000, "reset start");
		rd(8'h05, r);
		check(r[4:0] === 5'h00, "stack not empty");
		$display("reset test done");
		ex('0, b, d);
		for (int i = 0; i < 16; i++) begin
			o = mk(4'h1, i[3:0], 8'($urandom), 8'($urandom), 10'h000);
			ex(o, a, d);
			check(a === b + 10'h001 && d == 0, "counter step");
			check(instr_word === mw(a + 10'h001), "fetch word");
			if (alu_exp(o.func, o.opa, o.opb, r)) check(alu_result === r, "alu result");
			b = a;
		end
		ex(mk(4'h1, ALU_ADD, 8'hff, 8'h01, 10'h000), a, d);
		rd(8'h04, r);
		check(r[1:0] === 2'b11, "add flags");
		ex(mk(4'h2, ALU_AND, 8'h00, 8'h3c, 10'h000), b, d);
		ex('0, a, d);
		check(a === b + 10'h002 && d == 1, "skip taken");
		ex(mk(4'h2, ALU_AND, 8'hff, 8'h3c, 10'h000), b, d);
		ex('0, a, d);
		check(a === b + 10'h001 && d == 0, "skip not taken");
		$display("alu and skip test done");
		for (int i = 0; i < 4; i++) begin
			b = 10'($urandom) & 10'h2fe;
			ex(mk(4'h3, 4'h0, 8'h00, 8'h00, b), a, d);
			ex('0, a, d);
			check(a === b && d == 1, "jump target");
		end
		ex('0, a, d);
		rd(8'h00, r);
		check(r === a[7:0] + 8'h01, "low byte read");
		r = 8'($urandom);
		wr(8'h00, r);
		ex('0, a, d);
		ex('0, b, d);
		check(b === {a[9:8], r} && d == 1, "in-page branch");
		check(d == 1, "low write dummy");
		$display("branch test done");
		for (int k = 7; k < 10; k++) begin
			r = 8'($urandom);
			h = 8'($urandom);
			wr(8'h01, r);
			wr(8'h02, h);
			ex(mk(k[3:0], 4'h0, 8'h00, 8'h00, 10'h000), a, d);
			b = (k == 7) ? {a[9:8], r} : (k == 8) ? {2'b11, r} : {h[1:0], r};
			w = mw(b);
			ex('0, c, d);
			check(c === a + 10'h001 && d == 1, "table two cycles");
			check(tbl_low_data === w[7:0], "table low byte");
			rd(8'h03, r);
			check(r === w[15:8], "table high byte");
		end
		wr(8'h03, ~w[15:8]);
		rd(8'h03, r);
		check(r === w[15:8], "table high written");
		rd(8'h77, r);
		check(r === 8'h00, "unmapped read");
		$display("table test done");
		for (int i = 0; i < 5; i++) begin
			if (i == 4) begin
				rd(8'h05, r);
				check(r[4:0] === 5'h14, "stack full level");
				@(posedge ref_clk) irq_raise <= 1'b1;
				@(posedge ref_clk) irq_raise <= 1'b0;
			end
			b = 10'h100 + 10'(i * 16);
			ex(mk(4'h4, 4'h0, 8'h00, 8'h00, b), a, d);
			ra[i] = a + 10'h001;
			ex('0, a, d);
			check(a === b && d == 1, "call target");
		end
		rd(8'h05, r);
		check(acks == 0 && r[5] === 1'b1, "irq held while full");
		ex(back_op, a, d);
		repeat (3) begin
			ex('0, a, d);
			if (a === irq_vector) break;
		end
		check(a === irq_vector && acks == 1, "irq entry after pop");
		ex(iback_op, a, d);
		ex('0, a, d);
		check(a === ra[4] && rets == 1, "interrupt return");
		for (int i = 3; i >= 0; i--) begin
			ex(back_op, a, d);
			ex('0, a, d);
			check(a === (i > 0 ? ra[i] : 10'h000), "return order");
		end
		$display("stack test done");
		test_done();
	end
endmodule
`default_nettype wire
